// [rtl/accel_st_regs.svh]
`ifndef ACCEL_ST_REGS_SVH
`define ACCEL_ST_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_PRODUCT_REVISION      7'h12
`define ADDR_SENSOR_CONFIG_ONE     7'h15
`define ADDR_SELF_TEST_RATE_CONFIG 7'h38
`define ADDR_DATA_FIRST            7'h04
`define ADDR_DATA_LAST             7'h09

// ****************************************
// Fields and reset values
// ****************************************
`define CFG1_RESET         8'h00
`define CFG2_RESET         8'h00
`define CFG1_ACTIVE_BIT    0
`define CFG1_FSR_LSB       1
`define CFG1_POL_BIT       4
`define CFG1_AXIS_LSB      5
`define CFG1_SOFT_RST_BIT  7
`define RATE_DEC_WIDTH     3
`define RATE_100HZ         8'h05

// ****************************************
// Timing
// ****************************************
`define CLK_HZ              125000000
`define CLK_MHZ             125
`define ST_ODR_BASE_HZ      3200
`define ST_ODR_BASE_CYCLES  (`CLK_HZ / `ST_ODR_BASE_HZ)
`define PULSE_TIME_US       5000
`define ST_PULSE_CYCLES     (`PULSE_TIME_US * `CLK_MHZ)
`define STRAP_CAPTURE_CYCLE 2'h2

`endif

// [rtl/accel_st_pkg.sv]
package accel_st_pkg;
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'h0,
    SEQ_BUSY = 2'h1
  } seq_state_e;

  typedef enum logic [1:0]
  {
    AXIS_OFF = 2'h0,
    AXIS_X   = 2'h1,
    AXIS_Y   = 2'h2,
    AXIS_Z   = 2'h3
  } axis_sel_e;

  typedef logic [15:0] sample_t;
endpackage

// [rtl/reg_access_if.sv]
`timescale 1ns/10ps
interface reg_access_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport link (output addr, output wdata, output wr, output rd, input rdata);
  modport regs (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// [rtl/spi_reg_link.sv]
`timescale 1ns/10ps
module spi_reg_link
(
  input  wire logic    clk_i,      // Core clock
  input  wire logic    rstn_i,     // Async reset, active low
  input  wire logic    sclk_i,     // Serial clock pin
  input  wire logic    csn_i,      // Chip select pin, active low
  input  wire logic    mosi_i,     // Serial data in
  output logic         miso_o,     // Serial data out
  output logic         miso_oe_o,  // Drive enable for miso
  reg_access_if.link   bus         // Register access
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sclk_r;
  logic [1:0] csn_r;
  logic [1:0] mosi_r;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sclk_r <= 3'h0;
      csn_r  <= 2'h3;
      mosi_r <= 2'h0;
    end
    else
    begin
      sclk_r <= {sclk_r[1:0], sclk_i};
      csn_r  <= {csn_r[0], csn_i};
      mosi_r <= {mosi_r[0], mosi_i};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sel;
  assign sclk_rise = sclk_r[1] & ~sclk_r[2];
  assign sclk_fall = ~sclk_r[1] & sclk_r[2];
  assign sel       = ~csn_r[1];

  // ****************************************
  // Frame shifter: R/W bit, 7-bit address, data byte
  // ****************************************
  logic [4:0] cnt_r,   cnt_nxt;
  logic [7:0] sin_r,   sin_nxt;
  logic [7:0] sout_r,  sout_nxt;
  logic [6:0] addr_r,  addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic       read_r,  read_nxt;
  logic       rd_r,    rd_nxt;
  logic       ld_r,    ld_nxt;
  logic       wr_r,    wr_nxt;
  logic       miso_r,  miso_nxt;

  always_comb
  begin
    cnt_nxt   = cnt_r;
    sin_nxt   = sin_r;
    sout_nxt  = sout_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    read_nxt  = read_r;
    rd_nxt    = 1'b0;
    wr_nxt    = 1'b0;
    ld_nxt    = rd_r;
    miso_nxt  = miso_r;
    if (!sel)
      cnt_nxt = 5'h0;
    else if (sclk_rise)
    begin
      sin_nxt = {sin_r[6:0], mosi_r[1]};
      cnt_nxt = cnt_r + 5'h1;
      if (cnt_r == 5'h7)
      begin
        read_nxt = sin_r[6];
        addr_nxt = {sin_r[5:0], mosi_r[1]};
        rd_nxt   = sin_r[6];
      end
      if (cnt_r == 5'hf && !read_r)
      begin
        wdata_nxt = {sin_r[6:0], mosi_r[1]};
        wr_nxt    = 1'b1;
      end
    end
    else if (sclk_fall)
    begin
      miso_nxt = sout_r[7];
      sout_nxt = {sout_r[6:0], 1'b0};
    end
    // Load lands well before the next falling edge at any legal sclk
    if (ld_r)
      sout_nxt = bus.rdata;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_r   <= 5'h0;
      sin_r   <= 8'h00;
      sout_r  <= 8'h00;
      addr_r  <= 7'h00;
      wdata_r <= 8'h00;
      read_r  <= 1'b0;
      rd_r    <= 1'b0;
      ld_r    <= 1'b0;
      wr_r    <= 1'b0;
      miso_r  <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      sin_r   <= sin_nxt;
      sout_r  <= sout_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      read_r  <= read_nxt;
      rd_r    <= rd_nxt;
      ld_r    <= ld_nxt;
      wr_r    <= wr_nxt;
      miso_r  <= miso_nxt;
    end
  end

  assign bus.addr  = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr    = wr_r;
  assign bus.rd    = rd_r;
  assign miso_o    = miso_r;
  assign miso_oe_o = sel;
endmodule

// [rtl/accel_self_test_control.sv]
`timescale 1ns/10ps
`include "accel_st_regs.svh"
// Behaviour
// - Read-only revision byte, BCD major in bits 7..4, minor in 3..0.
// - Each axis is tested positive phase, then negative phase, the host writing the polarity bit.
// - Self-test rate is 3200 Hz after reset until reprogrammed.
// - Writing 05h to rate config gives a 100 Hz self-test rate.
// - Strap high: data-ready pulses for 5 ms then clears itself.
// - Strap low: data-ready clears when output data is read.
// - In self-test only the selected axis is converted.
// - Normal mode converts X, Y, Z in turn each cycle.
// - Scaling 128, 256, 512 counts per g at 16, 8, 4 g.
// - Link is a serial register bus plus an interrupt line.
// - Axis select 00 off, 01 X, 10 Y, 11 Z.
// - Polarity 0 drives mass positive, 1 negative.
// - Config always readable, writes only take effect in standby, except the active bit and soft reset.
// - Power-on, soft reset or hibernate exit restore defaults.
module accel_self_test_control #(
  parameter int unsigned ODR_BASE_CYCLES = `ST_ODR_BASE_CYCLES,
  parameter int unsigned PULSE_CYCLES    = `ST_PULSE_CYCLES,
  parameter logic [3:0]  REV_MAJOR       = 4'h2,  // Arbitrary value
  parameter logic [3:0]  REV_MINOR       = 4'h7   // Arbitrary value
)
(
  input  wire logic        clk_i,             // Core clock, 125 MHz
  input  wire logic        rstn_i,            // Power-on reset, active low
  input  wire logic        hibernate_exit_i,  // One-cycle pulse, core domain
  input  wire logic        boot_mode_strap_i, // Strap pin
  input  wire logic        sclk_i,            // Serial clock pin
  input  wire logic        csn_i,             // Chip select, active low
  input  wire logic        mosi_i,            // Serial data in
  output logic             miso_o,            // Serial data out
  output logic             miso_oe_o,         // Drive enable for miso
  input  wire logic [15:0] sample_i,          // Converter result
  input  wire logic        sample_valid_i,    // Result strobe
  output logic             conv_start_o,      // Start one axis conversion
  output logic [1:0]       conv_axis_o,       // Axis 0 X, 1 Y, 2 Z
  output logic             st_drive_o,        // Electrostatic drive on
  output logic             st_negative_o,     // Drive direction negative
  output logic             drdy_o             // Data-ready interrupt
);
  reg_access_if bus ();

  spi_reg_link u_link
  (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .sclk_i    (sclk_i),
    .csn_i     (csn_i),
    .mosi_i    (mosi_i),
    .miso_o    (miso_o),
    .miso_oe_o (miso_oe_o),
    .bus       (bus.link)
  );

  // ****************************************
  // Strap capture
  // ****************************************
  logic [1:0] strap_s_r;
  logic [1:0] scnt_r,  scnt_nxt;
  logic       strap_r, strap_nxt;

  always_comb
  begin
    scnt_nxt  = scnt_r;
    strap_nxt = strap_r;
    // Counter saturates so the strap is taken only once
    if (scnt_r != 2'h3)
      scnt_nxt = scnt_r + 2'h1;
    if (scnt_r == `STRAP_CAPTURE_CYCLE)
      strap_nxt = strap_s_r[1];
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      strap_s_r <= 2'h0;
      scnt_r    <= 2'h0;
      strap_r   <= 1'b0;
    end
    else
    begin
      strap_s_r <= {strap_s_r[0], boot_mode_strap_i};
      scnt_r    <= scnt_nxt;
      strap_r   <= strap_nxt;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] cfg1_r, cfg1_nxt;
  logic [7:0] cfg2_r, cfg2_nxt;
  logic       standby;
  logic       sw_reset;
  logic       st_on;
  logic [1:0] st_sel;
  logic [1:0] fsr;

  assign standby  = ~cfg1_r[`CFG1_ACTIVE_BIT];
  assign st_sel   = cfg1_r[`CFG1_AXIS_LSB +: 2];
  assign fsr      = cfg1_r[`CFG1_FSR_LSB +: 2];
  assign st_on    = st_sel != accel_st_pkg::AXIS_OFF;
  assign sw_reset = hibernate_exit_i
                  | (bus.wr & bus.addr == `ADDR_SENSOR_CONFIG_ONE
                     & bus.wdata[`CFG1_SOFT_RST_BIT]);

  always_comb
  begin
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    if (sw_reset)
    begin
      cfg1_nxt = `CFG1_RESET;
      cfg2_nxt = `CFG2_RESET;
    end
    else if (bus.wr && bus.addr == `ADDR_SENSOR_CONFIG_ONE)
    begin
      // Active bit stays writable so the host can return to standby
      if (standby)
        cfg1_nxt = bus.wdata;
      else
        cfg1_nxt[`CFG1_ACTIVE_BIT] = bus.wdata[`CFG1_ACTIVE_BIT];
    end
    else if (bus.wr && bus.addr == `ADDR_SELF_TEST_RATE_CONFIG && standby)
      cfg2_nxt = bus.wdata;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg1_r <= `CFG1_RESET;
      cfg2_r <= `CFG2_RESET;
    end
    else
    begin
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
    end
  end

  // ****************************************
  // Output data rate timer
  // ****************************************
  logic [23:0] period;
  logic [23:0] odr_cnt_r, odr_cnt_nxt;
  logic        tick;

  // Base rate halves per decimation step: 0 gives 3200 Hz, 05h 100 Hz
  assign period = 24'(ODR_BASE_CYCLES) << cfg2_r[`RATE_DEC_WIDTH-1:0];
  assign tick   = ~standby & (odr_cnt_r == period - 24'h1);

  always_comb
  begin
    odr_cnt_nxt = odr_cnt_r + 24'h1;
    if (standby || tick)
      odr_cnt_nxt = 24'h0;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      odr_cnt_r <= 24'h0;
    else
      odr_cnt_r <= odr_cnt_nxt;
  end

  // ****************************************
  // Axis sequencer and output data
  // ****************************************
  function automatic logic [15:0] scale_fsr(input logic [15:0] raw, input logic [1:0] r);
    scale_fsr = 16'($signed(raw) >>> r);
  endfunction

  accel_st_pkg::seq_state_e state_r, state_nxt;
  logic [1:0]              axis_r,  axis_nxt;
  logic                    start_r, start_nxt;
  accel_st_pkg::sample_t   data_r   [3];
  accel_st_pkg::sample_t   data_nxt [3];
  logic                    drdy_set;

  always_comb
  begin
    state_nxt = state_r;
    axis_nxt  = axis_r;
    start_nxt = 1'b0;
    data_nxt  = data_r;
    drdy_set  = 1'b0;
    unique case (state_r)
      accel_st_pkg::SEQ_IDLE:
        if (tick)
        begin
          axis_nxt  = st_on ? st_sel - 2'h1 : 2'h0;
          start_nxt = 1'b1;
          state_nxt = accel_st_pkg::SEQ_BUSY;
        end
      accel_st_pkg::SEQ_BUSY:
        if (sample_valid_i)
        begin
          data_nxt[axis_r] = scale_fsr(sample_i, fsr);
          if (st_on || axis_r == 2'h2)
          begin
            drdy_set  = 1'b1;
            state_nxt = accel_st_pkg::SEQ_IDLE;
          end
          else
          begin
            axis_nxt  = axis_r + 2'h1;
            start_nxt = 1'b1;
          end
        end
      default:
        state_nxt = accel_st_pkg::SEQ_IDLE;
    endcase
    if (sw_reset || standby)
      state_nxt = accel_st_pkg::SEQ_IDLE;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= accel_st_pkg::SEQ_IDLE;
      axis_r  <= 2'h0;
      start_r <= 1'b0;
      data_r  <= '{default: 16'h0000};
    end
    else
    begin
      state_r <= state_nxt;
      axis_r  <= axis_nxt;
      start_r <= start_nxt;
      data_r  <= data_nxt;
    end
  end

  assign conv_start_o  = start_r;
  assign conv_axis_o   = axis_r;
  // Host runs the axis twice, polarity 0 then 1
  assign st_drive_o    = st_on & ~standby;
  assign st_negative_o = cfg1_r[`CFG1_POL_BIT];

  // ****************************************
  // Data-ready interrupt
  // ****************************************
  logic        data_read;
  logic        drdy_r, drdy_nxt;
  logic [23:0] pcnt_r, pcnt_nxt;

  assign data_read = bus.rd & bus.addr >= `ADDR_DATA_FIRST & bus.addr <= `ADDR_DATA_LAST;

  always_comb
  begin
    drdy_nxt = drdy_r;
    pcnt_nxt = pcnt_r;
    if (strap_r && drdy_r)
    begin
      pcnt_nxt = pcnt_r - 24'h1;
      if (pcnt_r == 24'h0)
        drdy_nxt = 1'b0;
    end
    else if (!strap_r && data_read)
      drdy_nxt = 1'b0;
    // New data wins over a read or pulse-end clear in the same cycle; soft reset wins over new data
    if (drdy_set)
    begin
      drdy_nxt = 1'b1;
      pcnt_nxt = 24'(PULSE_CYCLES - 1);
    end
    if (sw_reset)
      drdy_nxt = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      drdy_r <= 1'b0;
      pcnt_r <= 24'h0;
    end
    else
    begin
      drdy_r <= drdy_nxt;
      pcnt_r <= pcnt_nxt;
    end
  end

  assign drdy_o = drdy_r;

  // ****************************************
  // Read decode
  // ****************************************
  function automatic logic [7:0] read_mux(input logic [6:0] a);
    logic [6:0] idx;
    idx = a - `ADDR_DATA_FIRST;
    if (a == `ADDR_PRODUCT_REVISION)
      read_mux = {REV_MAJOR, REV_MINOR};
    else if (a == `ADDR_SENSOR_CONFIG_ONE)
      read_mux = cfg1_r;
    else if (a == `ADDR_SELF_TEST_RATE_CONFIG)
      read_mux = cfg2_r;
    else if (a >= `ADDR_DATA_FIRST && a <= `ADDR_DATA_LAST)
      read_mux = idx[0] ? data_r[idx[2:1]][15:8] : data_r[idx[2:1]][7:0];
    else
      read_mux = 8'h00;
  endfunction

  // Process form so register changes re-run the decode, not only address changes
  always_comb bus.rdata = read_mux(bus.addr);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic [23:0] hi_len_r;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      hi_len_r <= 24'h0;
    else if (drdy_set)
      hi_len_r <= 24'h0;
    else if (drdy_o)
      hi_len_r <= hi_len_r + 24'h1;
  end

  sequence seq_axis_done(logic [1:0] n);
    sample_valid_i && state_r == accel_st_pkg::SEQ_BUSY && axis_r == n && !st_on
      && !standby && !sw_reset;
  endsequence

  sequence seq_next_axis(logic [1:0] n);
    conv_start_o && conv_axis_o == n;
  endsequence

  chk_rev_value: assert property (bus.addr == `ADDR_PRODUCT_REVISION |->
    bus.rdata == {REV_MAJOR, REV_MINOR}) else $error("revision byte wrong");
  chk_rate_default: assert property (sw_reset |=> period == 24'(ODR_BASE_CYCLES))
    else $error("rate not back to base");
  chk_rate_slow: assert property (cfg2_r == `RATE_100HZ |->
    period == 24'(ODR_BASE_CYCLES) * 24'h20) else $error("05h not 100 Hz");
  chk_pulse_len: assert property ($fell(drdy_o) && strap_r && !$past(sw_reset) |->
    hi_len_r == 24'(PULSE_CYCLES)) else $error("pulse width wrong");
  chk_read_clear: assert property (!strap_r && data_read && !drdy_set && !sw_reset |=>
    !drdy_o) else $error("read did not clear");
  chk_single_axis: assert property (conv_start_o && st_on |->
    conv_axis_o == st_sel - 2'h1) else $error("wrong axis in self-test");
  chk_x_to_y: assert property (seq_axis_done(2'h0) |=>
    seq_next_axis(2'h1)) else $error("Y not after X");
  chk_y_to_z: assert property (seq_axis_done(2'h1) |=>
    seq_next_axis(2'h2)) else $error("Z not after Y");
  chk_active_lock: assert property (bus.wr && !standby && !sw_reset |=>
    $stable(cfg2_r)) else $error("write while active");
  chk_drive_dir: assert property (st_drive_o |-> st_negative_o == cfg1_r[`CFG1_POL_BIT]
    && !standby) else $error("drive direction wrong");
  chk_hib_default: assert property (hibernate_exit_i |=> cfg1_r == `CFG1_RESET
    && cfg2_r == `CFG2_RESET && !drdy_o) else $error("defaults not restored");
endmodule

// [tb/spi_host_model.sv]
`timescale 1ns/10ps
// ****************************************
// Host side of the serial register link
// ****************************************
module spi_host_model
(
  input  wire logic clk_i,     // Core clock, frames start after an edge
  input  wire logic miso_i,    // Device data out
  input  wire logic miso_oe_i, // Device drive enable
  output logic      sclk_o,    // Serial clock, low between frames
  output logic      csn_o,     // Chip select, active low
  output logic      mosi_o     // Serial data to the device
);
  logic miso_last = 1'b0;
  logic miso_w;

  // Released line shows the inverse of its last level, so stale data cannot pass
  always @(posedge clk_i)
  begin
    if (miso_oe_i)
      miso_last <= miso_i;
  end
  assign miso_w = miso_oe_i ? miso_i : ~miso_last;

  initial
  begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    mosi_o = 1'b0;
  end

  // One 16-bit frame, mode 0, 125 ns serial period
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_i);
    #1;
    csn_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi_o = frame[i];
      #62.5;
      sclk_o = 1'b1;
      if (i < 8)
        rd[i] = miso_w;
      #62.5;
      sclk_o = 1'b0;
    end
    #62.5;
    csn_o  = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
endmodule

// [tb/accel_self_test_control_bench.sv]
`timescale 1ns/10ps
`include "accel_st_regs.svh"
module accel_self_test_control_bench;
  localparam int unsigned ODR_CYC   = 50;
  localparam int unsigned PULSE_CYC = 20;
  localparam logic [3:0]  REV_MAJ   = 4'h3;  // Arbitrary value
  localparam logic [3:0]  REV_MIN   = 4'h1;  // Arbitrary value
  localparam logic [15:0] RAW_X     = 16'h0400;
  localparam logic [15:0] RAW_Y     = 16'hf800;
  localparam logic [15:0] ST_OFS    = 16'h0100;

  logic        clk_i;
  logic        rstn_i;
  logic        hibernate_exit_i;
  logic        boot_mode_strap_i;
  logic        sclk, csn, mosi, miso, miso_oe;
  logic [15:0] sample_i;
  logic        sample_valid_i;
  logic        conv_start, st_drive, st_negative, drdy;
  logic [1:0]  conv_axis;
  int          error_cnt;
  int          checks;

  initial clk_i = 1'b0;
  always #4 clk_i = ~clk_i;

  accel_self_test_control #(.ODR_BASE_CYCLES(ODR_CYC), .PULSE_CYCLES(PULSE_CYC),
    .REV_MAJOR(REV_MAJ), .REV_MINOR(REV_MIN)) dut
  (
    .clk_i(clk_i), .rstn_i(rstn_i), .hibernate_exit_i(hibernate_exit_i),
    .boot_mode_strap_i(boot_mode_strap_i), .sclk_i(sclk), .csn_i(csn), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .conv_start_o(conv_start), .conv_axis_o(conv_axis),
    .st_drive_o(st_drive), .st_negative_o(st_negative), .drdy_o(drdy)
  );

  spi_host_model host
  (
    .clk_i(clk_i), .miso_i(miso), .miso_oe_i(miso_oe),
    .sclk_o(sclk), .csn_o(csn), .mosi_o(mosi)
  );

  // ****************************************
  // Converter stand-in, answers 3 cycles after each start
  // ****************************************
  always
  begin
    @(posedge clk_i);
    #1;
    while (conv_start === 1'b1)
    begin
      sample_i = (conv_axis == 2'h0) ? RAW_X : (conv_axis == 2'h1) ? RAW_Y : 16'h0123;
      // Drive adds a fixed offset whose sign follows the polarity
      if (st_drive)
        sample_i = st_negative ? sample_i - ST_OFS : sample_i + ST_OFS;
      repeat (3) @(posedge clk_i);
      #1;
      sample_valid_i = 1'b1;
      @(posedge clk_i);
      #1;
      sample_valid_i = 1'b0;
    end
  end

  // ****************************************
  // Access and check tasks
  // ****************************************
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    error_cnt++;
    $display("mismatch %s expected event seen none", what);
    close_out();
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer({1'b0, a, d}, unused);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
    logic [7:0] got;
    host.xfer({1'b1, a, 8'h00}, got);
    chk(what, {8'h00, exp}, {8'h00, got});
  endtask

  task automatic next_start(output int gap, output logic [1:0] ax);
    gap = 0;
    ax  = 2'h0;
    do
    begin
      @(posedge clk_i);
      #1;
      gap++;
    end
    while (conv_start !== 1'b1 && gap < 20000);
    if (conv_start !== 1'b1)
      timeout("conversion start");
    else
      ax = conv_axis;
  endtask

  task automatic wait_drdy;
    int n;
    n = 0;
    while (drdy !== 1'b1 && n < 20000)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (drdy !== 1'b1)
      timeout("data ready");
  endtask

  task automatic do_reset(input logic strap);
    boot_mode_strap_i = strap;
    rstn_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [7:0]        cfg;
    logic [7:0]        got;
    logic [1:0]        ax;
    logic signed [15:0] ex, ey;
    int                gap;
    int                n;
    logic [15:0]       xs [2];
    error_cnt = 0;
    checks = 0;
    hibernate_exit_i = 1'b0;
    sample_i = 16'h0000;
    sample_valid_i = 1'b0;
    do_reset(1'b0);

    rd(`ADDR_PRODUCT_REVISION, {REV_MAJ, REV_MIN}, "revision");
    chk("miso drive idle", 16'h0000, {15'h0000, miso_oe});
    wr(`ADDR_PRODUCT_REVISION, 8'hff);
    rd(`ADDR_PRODUCT_REVISION, {REV_MAJ, REV_MIN}, "revision after write");
    rd(`ADDR_SENSOR_CONFIG_ONE, `CFG1_RESET, "config one reset");
    rd(`ADDR_SELF_TEST_RATE_CONFIG, `CFG2_RESET, "rate config reset");
    rd(7'h40, 8'h00, "unmapped");
    $display("test registers done");

    for (int sel = 0; sel < 4; sel++)
      for (int pol = 0; pol < 2; pol++)
      begin
        cfg = {1'b0, sel[1:0], pol[0], 4'h2};
        wr(`ADDR_SENSOR_CONFIG_ONE, 8'h00);
        wr(`ADDR_SENSOR_CONFIG_ONE, cfg);
        wr(`ADDR_SENSOR_CONFIG_ONE, cfg | 8'h01);
        chk("test drive", {15'h0000, sel != 0}, {15'h0000, st_drive});
        chk("polarity", {15'h0000, pol[0]}, {15'h0000, st_negative});
        rd(`ADDR_SENSOR_CONFIG_ONE, cfg | 8'h01, "config one readback");
        next_start(gap, ax);
        if (sel == 0)
        begin
          for (int k = 0; k < 3 && ax !== 2'h0; k++)
            next_start(gap, ax);
          next_start(gap, ax);
          chk("normal second axis", 16'h0001, {14'h0000, ax});
          next_start(gap, ax);
          chk("normal third axis", 16'h0002, {14'h0000, ax});
        end
        else
        begin
          chk("test axis", 16'(sel - 1), {14'h0000, ax});
          next_start(gap, ax);
          chk("test axis again", 16'(sel - 1), {14'h0000, ax});
        end
      end
    $display("test modes done");

    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h00);
    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h23);
    next_start(gap, ax);
    next_start(gap, ax);
    chk("default period", 16'(ODR_CYC), gap[15:0]);
    wr(`ADDR_SELF_TEST_RATE_CONFIG, 8'h05);
    rd(`ADDR_SELF_TEST_RATE_CONFIG, `CFG2_RESET, "rate write while active");
    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h00);
    wr(`ADDR_SELF_TEST_RATE_CONFIG, `RATE_100HZ);
    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h23);
    next_start(gap, ax);
    next_start(gap, ax);
    chk("slow period", 16'(ODR_CYC << 5), gap[15:0]);
    $display("test rate done");

    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h00);
    wr(`ADDR_SELF_TEST_RATE_CONFIG, 8'h07);
    for (int f = 1; f < 4; f++)
    begin
      wr(`ADDR_SENSOR_CONFIG_ONE, 8'h00);
      host.xfer({1'b1, `ADDR_DATA_FIRST, 8'h00}, got);
      wr(`ADDR_SENSOR_CONFIG_ONE, 8'(f << 1) | 8'h01);
      wait_drdy();
      ex = $signed(RAW_X) >>> f;
      ey = $signed(RAW_Y) >>> f;
      rd(7'h05, ex[15:8], "x high");
      chk("data ready after read", 16'h0000, {15'h0000, drdy});
      rd(7'h04, ex[7:0], "x low");
      rd(7'h07, ey[15:8], "y high");
    end
    $display("test scaling done");

    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h00);
    wr(`ADDR_SELF_TEST_RATE_CONFIG, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      wr(`ADDR_SENSOR_CONFIG_ONE, 8'h00);
      host.xfer({1'b1, `ADDR_DATA_FIRST, 8'h00}, got);
      wr(`ADDR_SENSOR_CONFIG_ONE, 8'h23 | 8'(p << 4));
      wait_drdy();
      host.xfer({1'b1, 7'h05, 8'h00}, got);
      xs[p][15:8] = got;
      host.xfer({1'b1, `ADDR_DATA_FIRST, 8'h00}, got);
      xs[p][7:0] = got;
      chk("x clipped", 16'h0000, {15'h0000, xs[p] == 16'h7fff || xs[p] == 16'h8000});
    end
    // Four g range halves both offsets, so the difference is one offset
    chk("test response", ST_OFS, xs[0] - xs[1]);
    $display("test response done");

    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h00);
    wr(`ADDR_SELF_TEST_RATE_CONFIG, 8'h05);
    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h52);
    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h80);
    rd(`ADDR_SENSOR_CONFIG_ONE, `CFG1_RESET, "config one soft reset");
    rd(`ADDR_SELF_TEST_RATE_CONFIG, `CFG2_RESET, "rate soft reset");
    wr(`ADDR_SELF_TEST_RATE_CONFIG, 8'h05);
    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h52);
    hibernate_exit_i = 1'b1;
    @(posedge clk_i);
    #1;
    hibernate_exit_i = 1'b0;
    rd(`ADDR_SENSOR_CONFIG_ONE, `CFG1_RESET, "config one hibernate");
    rd(`ADDR_SELF_TEST_RATE_CONFIG, `CFG2_RESET, "rate hibernate");
    $display("test resets done");

    // Strap is only taken after reset, so a second reset sets it high
    do_reset(1'b1);
    wr(`ADDR_SELF_TEST_RATE_CONFIG, 8'h07);
    wr(`ADDR_SENSOR_CONFIG_ONE, 8'h03);
    wait_drdy();
    n = 0;
    while (drdy === 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk("pulse length", 16'(PULSE_CYC), n[15:0]);
    $display("test pulse done");
    close_out();
  end
endmodule
